/* File: core/ring_talk_pkg.sv */
package ring_talk_pkg;

  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD    = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CFG    = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_HALF   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hc;

  // command codes written to the low bits of CMD
  localparam logic [2:0] CMD_RING     = 3'h1;
  localparam logic [2:0] CMD_TALK_MBB = 3'h2;
  localparam logic [2:0] CMD_TALK_BBM = 3'h3;
  localparam logic [2:0] CMD_TALK_SD  = 3'h4;

  // CFG fields
  localparam int CFG_VER_C_BIT = 0;
  localparam int CFG_LATCH_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // STATUS fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_ERR_BIT   = 1;
  localparam int ST_THERM_BIT = 2;
  localparam int ST_OP_LSB    = 4;

  // half ringing period: 25 ms at 20 Hz ringing, 100 MHz clock
  localparam int  CLK_HZ       = 100_000_000;
  localparam int  RING_HALF_US = 25_000;
  localparam logic [31:0] HALF_RESET = 32'(64'(RING_HALF_US) * 64'(CLK_HZ) / 64'd1_000_000);

  // select pairs {ringing_select, test_select}
  localparam logic [1:0] SEL_RING   = 2'h2;
  localparam logic [1:0] SEL_TALK   = 2'h0;
  localparam logic [1:0] SEL_ALLOFF = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {st_idle, st_hold} seq_state_e;

endpackage

/* File: core/ring_to_talk_switch_sequencer.sv */
// Contract
// - make-before-break: ringing pair straight to talk pair
// - input break-before-make applies all-off pair first
// - hold all-off at least half ringing cycle
// - break switches close only after feed opens
// - keep shutdown low at least half cycle
// - set talk pair while shutdown held low
// - shutdown pin driven low or floated only
// - never drive shutdown pin high
// - version C uses shutdown method only; code refuses break-before-make but still runs make-before-break
`timescale 1ns/1ns
module ring_to_talk_switch_sequencer
  import ring_talk_pkg::*;
(
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // axi4-lite write address
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [ring_talk_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  // axi4-lite write data and response
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [ring_talk_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  // axi4-lite read
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [ring_talk_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [ring_talk_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  // device control pins
  output logic                                ringing_select,
  output logic                                test_select,
  output logic                                latch_enable,
  input  wire logic                           shutdown_override_pin_i,
  output logic                                shutdown_override_pin_o,
  output logic                                shutdown_override_pin_oe_n
);
  import ring_talk_pkg::*;

  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [1:0]        rresp_reg, rresp_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              aw_ok_reg, aw_ok_next;
  logic              w_ok_reg, w_ok_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;

  logic [1:0]        cfg_reg, cfg_next;
  logic [31:0]       half_reg, half_next;
  logic              err_reg, err_next;
  logic              therm_reg, therm_next;

  seq_state_e        state_reg, state_next;
  logic [2:0]        op_reg, op_next;
  logic [31:0]       count_reg, count_next;
  logic [1:0]        sel_reg, sel_next;
  logic              latch_reg, latch_next;
  logic              sd_oe_n_reg, sd_oe_n_next;

  logic              cmd_go;
  logic [2:0]        cmd_code;
  logic              cmd_bad;
  logic [31:0]       half_wr;

  always_comb begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    aw_ok_next   = aw_ok_reg;
    w_ok_next    = w_ok_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    cfg_next     = cfg_reg;
    half_next    = half_reg;
    err_next     = err_reg;
    state_next   = state_reg;
    op_next      = op_reg;
    count_next   = count_reg;
    sel_next     = sel_reg;
    latch_next   = latch_reg;
    sd_oe_n_next = sd_oe_n_reg;
    cmd_go       = 1'b0;
    cmd_code     = 3'h0;
    cmd_bad      = 1'b0;
    half_wr      = half_reg;

    // thermal shutdown shows as the pin low while we are floating it
    therm_next = sd_oe_n_reg & ~shutdown_override_pin_i;

    if (s_axi_awvalid && awready_reg) begin
      aw_ok_next  = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_ok_next  = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end

    if (aw_ok_reg && w_ok_reg && !bvalid_reg) begin
      aw_ok_next  = 1'b0;
      w_ok_next   = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      case ({awaddr_reg[ADDR_W-1:2], 2'b00})
        OFF_CMD: begin
          cmd_go   = wstrb_reg[0];
          cmd_code = wdata_reg[2:0];
        end
        OFF_CFG: begin
          if (wstrb_reg[0]) begin
            cfg_next = wdata_reg[1:0];
          end
        end
        OFF_HALF: begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_reg[b]) begin
              half_wr[b*8 +: 8] = wdata_reg[b*8 +: 8];
            end
          end
          // zero is stored as one; with the >= compare both give a one-cycle hold
          half_next = (half_wr == 32'h0) ? 32'h1 : half_wr;
        end
        OFF_STATUS: begin
          if (wstrb_reg[0] && wdata_reg[ST_ERR_BIT]) begin
            err_next = 1'b0;
          end
        end
        default: bresp_next = RESP_DECERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_ok_next && !bvalid_next;
    wready_next  = !w_ok_next && !bvalid_next;

    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = '0;
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFF_CMD:  rdata_next[2:0] = op_reg;
        OFF_CFG:  rdata_next[1:0] = cfg_reg;
        OFF_HALF: rdata_next      = half_reg;
        OFF_STATUS: begin
          rdata_next[ST_BUSY_BIT]          = (state_reg == st_hold);
          rdata_next[ST_ERR_BIT]           = err_reg;
          rdata_next[ST_THERM_BIT]         = therm_reg;
          rdata_next[ST_OP_LSB +: 3]       = op_reg;
        end
        default: rresp_next = RESP_DECERR;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;

    case (state_reg)
      st_idle: begin
        latch_next = cfg_reg[CFG_LATCH_BIT];
        if (cmd_go) begin
          // latch goes transparent so the new pair reaches the switches
          latch_next = 1'b0;
          count_next = 32'h0;
          op_next    = cmd_code;
          case (cmd_code)
            CMD_RING: begin
              sel_next = SEL_RING;
            end
            CMD_TALK_MBB: begin
              // straight to talk, the device overlaps for under half a cycle
              sel_next   = SEL_TALK;
              state_next = st_hold;
            end
            CMD_TALK_BBM: begin
              if (cfg_reg[CFG_VER_C_BIT]) begin
                cmd_bad = 1'b1;
                op_next = op_reg;
              end else begin
                sel_next   = SEL_ALLOFF;
                state_next = st_hold;
              end
            end
            CMD_TALK_SD: begin
              sd_oe_n_next = 1'b0;
              state_next   = st_hold;
            end
            default: begin
              cmd_bad = 1'b1;
              op_next = op_reg;
            end
          endcase
        end
      end
      st_hold: begin
        latch_next = 1'b0;
        count_next = count_reg + 32'h1;
        if (cmd_go) begin
          cmd_bad = 1'b1;
        end
        if (op_reg == CMD_TALK_SD && count_reg == 32'h0) begin
          sel_next = SEL_TALK;
        end
        if (count_next >= half_reg) begin
          state_next = st_idle;
          if (op_reg == CMD_TALK_BBM) begin
            // feed switch has seen a zero crossing by now
            sel_next = SEL_TALK;
          end
          if (op_reg == CMD_TALK_SD) begin
            sd_oe_n_next = 1'b1;
          end
        end
      end
      default: state_next = st_idle;
    endcase

    // a refusal in the same cycle as a clear still lands
    if (cmd_bad) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
      aw_ok_reg   <= 1'b0;
      w_ok_reg    <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= 4'h0;
      cfg_reg     <= CFG_RESET;
      half_reg    <= HALF_RESET;
      err_reg     <= 1'b0;
      therm_reg   <= 1'b0;
      state_reg   <= st_idle;
      op_reg      <= 3'h0;
      count_reg   <= 32'h0;
      sel_reg     <= SEL_TALK;
      latch_reg   <= 1'b0;
      sd_oe_n_reg <= 1'b1;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      aw_ok_reg   <= aw_ok_next;
      w_ok_reg    <= w_ok_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      cfg_reg     <= cfg_next;
      half_reg    <= half_next;
      err_reg     <= err_next;
      therm_reg   <= therm_next;
      state_reg   <= state_next;
      op_reg      <= op_next;
      count_reg   <= count_next;
      sel_reg     <= sel_next;
      latch_reg   <= latch_next;
      sd_oe_n_reg <= sd_oe_n_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign ringing_select = sel_reg[1];
  assign test_select    = sel_reg[0];
  assign latch_enable   = latch_reg;
  // pin is only ever pulled low or left to the device pull-up
  assign shutdown_override_pin_o    = 1'b0;
  assign shutdown_override_pin_oe_n = sd_oe_n_reg;

endmodule

/* File: tb/line_switch_model.sv */
`timescale 1ns/1ns
module line_switch_model (
  // select inputs
  input  wire logic ringing_select,
  input  wire logic test_select,
  input  wire logic latch_enable,
  input  wire logic shutdown_level,
  // line events
  input  wire logic zero_cross,
  input  wire logic overheat,
  // switch states
  output logic      tip_break_switch,
  output logic      ring_break_switch,
  output logic      ringing_return_switch,
  output logic      ringing_feed_switch,
  output logic      tip_test_switch,
  output logic      ring_test_switch,
  output logic      thermal_pull_n
);
  logic [1:0] held;
  logic       on;
  logic       feed_cmd;
  always_latch if (!latch_enable) held <= {ringing_select, test_select};
  assign thermal_pull_n = !overheat;
  assign on = shutdown_level && !overheat;
  assign feed_cmd = on && held == 2'h2;
  assign ringing_return_switch = feed_cmd;
  assign tip_break_switch = on && held == 2'h0;
  assign ring_break_switch = tip_break_switch;
  assign tip_test_switch = on && held == 2'h1;
  assign ring_test_switch = tip_test_switch;
  // feed only lets go at a current zero, whatever the inputs say
  initial ringing_feed_switch = 1'h0;
  always @(posedge feed_cmd or posedge zero_cross) begin
    ringing_feed_switch <= feed_cmd;
  end
endmodule

/* File: tb/ring_talk_sva.sv */
`timescale 1ns/1ns
module ring_talk_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // device pins
  input wire logic ringing_select,
  input wire logic test_select,
  input wire logic latch_enable,
  input wire logic shutdown_override_pin_o,
  input wire logic shutdown_override_pin_oe_n
);
  logic [1:0] sel;
  logic       oe_n;
  assign sel = {ringing_select, test_select};
  assign oe_n = shutdown_override_pin_oe_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // repeat counts assume the bench programs a half cycle of 8 clocks
  property p_ring_exit; ($past(sel) == 2'h2 && sel != 2'h2) |-> sel != 2'h1; endproperty
  a_ring_exit: assert property (p_ring_exit) else $error("odd pair after ringing");
  property p_bbm_hold; ($past(sel) == 2'h2 && sel == 2'h3) |-> (sel == 2'h3) [*8] ##1 sel == 2'h0;
  endproperty
  a_bbm_hold: assert property (p_bbm_hold) else $error("all-off hold wrong");
  property p_bbm_talk; ($past(sel) == 2'h3 && sel != 2'h3) |-> sel == 2'h0 && oe_n; endproperty
  a_bbm_talk: assert property (p_bbm_talk) else $error("all-off left badly");
  property p_sd_hold; $fell(oe_n) |-> !oe_n [*8] ##1 oe_n; endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown low time wrong");
  property p_sd_talk; $fell(oe_n) |=> (sel == 2'h0) [*7]; endproperty
  a_sd_talk: assert property (p_sd_talk) else $error("no talk pair under shutdown");
  property p_sd_rel; $rose(oe_n) |-> sel == 2'h0 && $past(sel) == 2'h0; endproperty
  a_sd_rel: assert property (p_sd_rel) else $error("released before talk pair");
  property p_od_low; !oe_n |-> !shutdown_override_pin_o; endproperty
  a_od_low: assert property (p_od_low) else $error("pin not pulled low");
  property p_no_high; shutdown_override_pin_o == 1'h0; endproperty
  a_no_high: assert property (p_no_high) else $error("pin driven high");
  property p_latch; !oe_n |-> !latch_enable; endproperty
  a_latch: assert property (p_latch) else $error("latch closed in sequence");
  c_mbb: cover property ($past(sel) == 2'h2 && sel == 2'h0 && oe_n);
  c_bbm: cover property ($past(sel) == 2'h2 && sel == 2'h3);
  c_sd: cover property ($fell(oe_n));
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module testbench;
  import ring_talk_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, zero_cross = 1'h0, overheat = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic ringing_select, test_select, latch_enable, sd_pin, sd_o, sd_oe_n;
  logic tb_sw, rb_sw, ret_sw, feed_sw, tt_sw, rt_sw, therm_n;
  logic [31:0] bad [4] = '{32'h0, 32'h5, 32'h6, 32'h7};
  int failures = 0, check_count = 0;
  always #5 aclk = ~aclk;
  ring_to_talk_switch_sequencer dut_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .ringing_select, .test_select, .latch_enable, .shutdown_override_pin_i(sd_pin),
    .shutdown_override_pin_o(sd_o), .shutdown_override_pin_oe_n(sd_oe_n));
  // pull-up wins unless the controller or a hot device sinks the pin
  assign sd_pin = sd_oe_n ? therm_n : sd_o;
  line_switch_model dev_u (.ringing_select, .test_select, .latch_enable, .shutdown_level(sd_pin),
    .zero_cross, .overheat, .tip_break_switch(tb_sw), .ring_break_switch(rb_sw),
    .ringing_return_switch(ret_sw), .ringing_feed_switch(feed_sw), .tip_test_switch(tt_sw),
    .ring_test_switch(rt_sw), .thermal_pull_n(therm_n));
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bail(input int n);
    if (n >= 200) begin
      failures++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'h0;
    bail(n);
    `CHK("bresp", RESP_OKAY, s_axi_bresp);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 200);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    bail(n);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd_reg(OFF_STATUS);
      n++;
    end while (rd[ST_BUSY_BIT] !== 1'h0 && n < 200);
    bail(n);
  endtask
  task automatic zc();
    @(posedge aclk) zero_cross <= 1'h1;
    @(posedge aclk) zero_cross <= 1'h0;
  endtask
  // bits: breaks, return, feed, tests
  task automatic sw(input logic [5:0] e);
    @(posedge aclk);
    #1;
    `CHK("switches", e, {tb_sw, rb_sw, ret_sw, feed_sw, tt_sw, rt_sw});
  endtask
  task automatic err_clear();
    rd_reg(OFF_STATUS);
    `CHK("err", 1'h1, rd[ST_ERR_BIT]);
    wr(OFF_STATUS, 32'h2);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK("oe_n", 1'h1, sd_oe_n);
    rd_reg(OFF_CFG);
    `CHK("cfg", 32'h0, rd);
    rd_reg(OFF_HALF);
    `CHK("half", HALF_RESET, rd);
    // byte address bits are ignored and all four words are mapped, so 0x2 reads CMD
    rd_reg(4'h2);
    `CHK("alias_resp", RESP_OKAY, rr);
    `CHK("alias_data", 32'h0, rd);
    wr(OFF_HALF, 32'h8);
    wr(OFF_CMD, 32'(CMD_RING));
    sw(6'h0c);
    wr(OFF_CMD, 32'(CMD_TALK_MBB));
    sw(6'h34);
    zc();
    sw(6'h30);
    wait_idle();
    wr(OFF_CMD, 32'(CMD_RING));
    wr(OFF_CMD, 32'(CMD_TALK_BBM));
    sw(6'h04);
    zc();
    sw(6'h00);
    wait_idle();
    sw(6'h30);
    wr(OFF_CMD, 32'(CMD_TALK_MBB));
    wr(OFF_CMD, 32'(CMD_TALK_BBM));
    err_clear();
    wait_idle();
    foreach (bad[i]) begin
      wr(OFF_CMD, bad[i]);
      err_clear();
    end
    wr(OFF_CFG, 32'h1);
    wr(OFF_CMD, 32'(CMD_RING));
    wr(OFF_CMD, 32'(CMD_TALK_BBM));
    sw(6'h0c);
    err_clear();
    wr(OFF_CMD, 32'(CMD_TALK_SD));
    sw(6'h04);
    `CHK("pin", 1'h0, sd_pin);
    zc();
    sw(6'h00);
    wait_idle();
    sw(6'h30);
    rd_reg(OFF_CMD);
    `CHK("cmd", 32'(CMD_TALK_SD), rd);
    wr(OFF_CFG, 32'h2);
    sw(6'h30);
    `CHK("latch", 1'h1, latch_enable);
    @(posedge aclk) overheat <= 1'h1;
    sw(6'h00);
    rd_reg(OFF_STATUS);
    `CHK("thermal", 1'h1, rd[ST_THERM_BIT]);
    finish_test();
  end
endmodule
bind ring_to_talk_switch_sequencer ring_talk_sva chk_u (.aclk, .aresetn, .ringing_select,
  .test_select, .latch_enable, .shutdown_override_pin_o, .shutdown_override_pin_oe_n);
